// File: rtl/shade_engine.sv
// Pin-level model of the shading engine: command FIFO, memory strobes, sync, fill flags.
// Assumes the host keeps the bus rules; memory-side pins go to the bench.
`timescale 1ns/1ps
`default_nettype none
module shade_engine
    import shade_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    shade_if.device hbus,
    output logic [MA_W-1:0] vram_address_bus,
    output logic vram_drive_en,
    output logic row_strobe_n,
    output logic col_strobe_n,
    output logic ibuf_transfer_oe_n,
    output logic zbuf_transfer_oe_n,
    output logic ibuf_write_enable_n,
    output logic zbuf_write_enable_n,
    output logic zsect_write_enable_n,
    output logic mem_read_not_write,
    output logic [DATA_W-1:0] intensity_out,
    output logic intensity_oe,
    input wire logic [DATA_W-1:0] intensity_in,
    output logic [DATA_W-1:0] new_depth_bus,
    input wire logic [DATA_W-1:0] old_depth_bus,
    output logic [DATA_W-1:0] depth_result,
    input wire logic wait_req,
    output logic float_ack,
    output logic block_pixel_select,
    output logic sixteen_pixel_flag,
    output logic mask_index_select,
    output logic sync_ready_out,
    input wire logic sync_ready_in,
    output logic vram_access_pending_n,
    output logic first_pixel_flag_n,
    output logic scan_left_flag,
    output logic scan_right_flag,
    output logic scan_up_flag,
    output logic scan_down_flag
);
    // Reset is synchronised so a single-cycle pulse is enough to initialise.
    logic rst_s1_q, rst_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end
    logic wr_lvl_n, wr_fall, rd_lvl_n, rd_fall;
    strobe_sync u_wr (.core_clk(core_clk), .resetn(resetn),
        .strobe_n(hbus.host_write_strobe_n), .level_n(wr_lvl_n), .fall(wr_fall));
    strobe_sync u_rd (.core_clk(core_clk), .resetn(resetn),
        .strobe_n(hbus.host_read_strobe_n), .level_n(rd_lvl_n), .fall(rd_fall));
    // The strobe is two clocks late, so bus contents are delayed to match.
    logic [DATA_W-1:0] d_s1_q, d_s2_q;
    logic [ADDR_W-1:0] a_s1_q, a_s2_q;
    logic [DATA_W+ADDR_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wp_q, rp_q;
    logic [CNT_W-1:0] cnt_q;
    eng_state_t st_q;
    logic [DATA_W-1:0] arg_q, rd_data_q;
    logic [ADDR_W-1:0] cmd_q;
    logic [CNT_W-1:0] pix_q;
    logic [MA_W-1:0] ma_q;
    logic [DATA_W-1:0] zpipe1_q, zpipe2_q;
    logic pass_q;
    wire fifo_full = (cnt_q == FIFO_FULL_CNT);
    wire fifo_empty = (cnt_q == '0);
    wire push = wr_fall & ~fifo_full & (a_s2_q != CMD_PASS);
    wire pass = wr_fall & (a_s2_q == CMD_PASS);
    wire pop = (st_q == ST_IDLE) & ~fifo_empty & ~wait_req;
    wire [DATA_W+ADDR_W-1:0] head = fifo_mem[rp_q];
    wire run = ~wait_req;
    wire is16 = (cmd_q == CMD_DRAW16);
    wire is_img = (cmd_q == CMD_IMAGE_IN) | pass_q;
    wire is_zrd = (cmd_q == CMD_DEPTH_RD);
    wire is_ag = (cmd_q == CMD_AG_SRC) | (cmd_q == CMD_AG_DST);
    wire active = (st_q != ST_IDLE);
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            d_s1_q <= '0;
            d_s2_q <= '0;
            a_s1_q <= '0;
            a_s2_q <= '0;
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            d_s1_q <= hbus.d_from_host;
            d_s2_q <= d_s1_q;
            a_s1_q <= hbus.addr;
            a_s2_q <= a_s1_q;
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
        end
    end
    always_ff @(posedge core_clk) begin
        if (push) fifo_mem[wp_q] <= {a_s2_q, d_s2_q};
    end
    // Command sequencer: sync (skipped for pass-through), pending lead, then row/column cycles per pixel.
    logic [1:0] lead_q;
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            st_q <= ST_IDLE;
            arg_q <= '0;
            cmd_q <= '0;
            pix_q <= '0;
            ma_q <= '0;
            lead_q <= '0;
            pass_q <= 1'b0;
        end else if (run) begin
            case (st_q)
                ST_IDLE: begin
                    if (pop) begin
                        {cmd_q, arg_q} <= head;
                        pass_q <= 1'b0;
                        st_q <= ST_SYNC;
                    end else if (pass) begin
                        cmd_q <= CMD_PASS;
                        arg_q <= d_s2_q;
                        pass_q <= 1'b1;
                        st_q <= ST_PEND;
                        lead_q <= '0;
                    end
                end
                ST_SYNC: begin
                    lead_q <= '0;
                    if (!sync_ready_in) st_q <= ST_PEND;
                end
                ST_PEND: begin
                    lead_q <= lead_q + 1'b1;
                    pix_q <= pass_q ? LAST_PIXEL : PIXEL_COUNT;
                    ma_q <= (cmd_q == CMD_LINEAR) ? MA_W'(arg_q) :
                        {COORD_W'(arg_q[15:8]), COORD_W'(arg_q[7:0])};
                    if (lead_q == 2'(PEND_LEAD - 1)) st_q <= ST_ROW;
                end
                ST_ROW: st_q <= ST_COL;
                ST_COL: begin
                    pix_q <= pix_q - 1'b1;
                    ma_q <= ma_q + 1'b1;
                    st_q <= (pix_q == LAST_PIXEL) ? ST_DONE : ST_ROW;
                end
                ST_DONE: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    wire in_col = (st_q == ST_COL);
    wire mem_cyc = (st_q == ST_ROW) | in_col;
    wire first_pix = mem_cyc & (pix_q == PIXEL_COUNT);
    // Depth pipeline: old value arrives two clocks after the new one.
    logic rd_busy_q;
    always_ff @(posedge core_clk or negedge rst_q) begin
        if (!rst_q) begin
            zpipe1_q <= '0;
            zpipe2_q <= '0;
            depth_result <= '0;
            rd_data_q <= '0;
            rd_busy_q <= 1'b0;
            float_ack <= 1'b0;
            col_strobe_n <= 1'b1;
        end else begin
            zpipe1_q <= new_depth_bus;
            zpipe2_q <= zpipe1_q;
            depth_result <= (old_depth_bus < zpipe2_q) ? old_depth_bus : zpipe2_q;
            col_strobe_n <= ~(in_col & run);
            float_ack <= wait_req;
            if (rd_fall) rd_busy_q <= 1'b1;
            else if (rd_lvl_n) rd_busy_q <= 1'b0;
            if (rd_fall) rd_data_q <= intensity_in;
        end
    end
    assign hbus.d_from_dev = rd_data_q;
    assign hbus.d_dev_oe = rd_busy_q & ~rd_lvl_n;
    assign hbus.channel_busy_flag = active | ~fifo_empty;
    assign hbus.fifo_room_flag = ~fifo_full;
    assign hbus.image_transfer_busy = active & is_img;
    assign vram_drive_en = ~float_ack & ~wait_req;
    assign vram_address_bus = ma_q;
    assign row_strobe_n = ~mem_cyc;
    assign ibuf_transfer_oe_n = ~((st_q == ST_ROW) & ~is_zrd & is_img);
    assign zbuf_transfer_oe_n = ~((st_q == ST_ROW) & is_zrd);
    assign mem_read_not_write = is_zrd | rd_busy_q;
    assign ibuf_write_enable_n = ~(in_col & ~is_zrd);
    assign zbuf_write_enable_n = ~(in_col & ~is_zrd & ~is16);
    assign zsect_write_enable_n = 1'b1;
    assign block_pixel_select = active & is16;
    assign sixteen_pixel_flag = active & is16;
    assign mask_index_select = is16 ? in_col : (is_zrd & arg_q[0]);
    assign intensity_out = (is16 & in_col) ? MASK_ALL : arg_q;
    assign intensity_oe = mem_cyc & ~mem_read_not_write & vram_drive_en;
    assign new_depth_bus = arg_q;
    // Ready low when about to draw; address-generator ends pulse low after their cycle.
    assign sync_ready_out = is_ag ? ~(st_q == ST_DONE) : ~(st_q == ST_SYNC | mem_cyc);
    assign vram_access_pending_n = ~(st_q == ST_PEND | mem_cyc);
    assign first_pixel_flag_n = ~first_pix;
    assign scan_right_flag = in_col & ~arg_q[15];
    assign scan_left_flag = in_col & arg_q[15];
    assign scan_down_flag = (st_q == ST_DONE) & ~arg_q[14];
    assign scan_up_flag = (st_q == ST_DONE) & arg_q[14];
endmodule : shade_engine
`default_nettype wire

// File: rtl/shade_host.sv
// Host-side bus master: issues command writes and intensity reads over strobes.
// Assumes requests arrive on a simple valid/ready user port.
`timescale 1ns/1ps
`default_nettype none
module shade_host
    import shade_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    shade_if.host hbus,
    input wire logic req_valid,
    input wire logic req_read,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_data,
    output logic req_ready,
    output logic [DATA_W-1:0] rsp_data,
    output logic rsp_valid
);
    host_state_t st_q;
    logic [2:0] t_q;
    logic [DATA_W-1:0] d_q;
    logic [ADDR_W-1:0] a_q;
    // Writes wait for room; reads wait for the image transfer to finish.
    wire can_wr = hbus.fifo_room_flag;
    wire can_rd = ~hbus.image_transfer_busy;
    assign req_ready = (st_q == H_IDLE) & (req_read ? can_rd : can_wr);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= H_IDLE;
            t_q <= '0;
            d_q <= '0;
            a_q <= '0;
            rsp_data <= '0;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (st_q)
                H_IDLE: if (req_valid && req_ready) begin
                    d_q <= req_data;
                    a_q <= req_addr;
                    t_q <= '0;
                    st_q <= req_read ? H_RD : H_WR;
                end
                H_WR: begin
                    t_q <= t_q + 1'b1;
                    if (t_q == HOST_WR_LAST) st_q <= H_GAP;
                end
                H_RD: begin
                    t_q <= t_q + 1'b1;
                    if (t_q == HOST_RD_LAST) begin
                        rsp_data <= hbus.d_from_dev;
                        rsp_valid <= 1'b1;
                        st_q <= H_GAP;
                    end
                end
                H_GAP: st_q <= H_IDLE;
                default: st_q <= H_IDLE;
            endcase
        end
    end
    assign hbus.d_from_host = d_q;
    assign hbus.d_host_oe = (st_q == H_WR);
    assign hbus.addr = a_q;
    assign hbus.host_write_strobe_n = ~(st_q == H_WR);
    assign hbus.host_read_strobe_n = ~(st_q == H_RD);
endmodule : shade_host
`default_nettype wire

// File: rtl/shade_if.sv
// Pin bundle between host bus and shading engine; the memory-side pins are ports of the engine, not part of it.
// Assumes the bench resolves two-way pins from the enables.
`timescale 1ns/1ps
`default_nettype none
interface shade_if;
    import shade_pkg::*;
    logic [DATA_W-1:0] d_from_host;
    logic d_host_oe;
    logic [DATA_W-1:0] d_from_dev;
    logic d_dev_oe;
    logic [ADDR_W-1:0] addr;
    logic host_write_strobe_n;
    logic host_read_strobe_n;
    logic channel_busy_flag;
    logic fifo_room_flag;
    logic image_transfer_busy;
    modport device (input d_from_host, d_host_oe, addr, host_write_strobe_n,
        host_read_strobe_n, output d_from_dev, d_dev_oe, channel_busy_flag,
        fifo_room_flag, image_transfer_busy);
    modport host (output d_from_host, d_host_oe, addr, host_write_strobe_n,
        host_read_strobe_n, input d_from_dev, d_dev_oe, channel_busy_flag,
        fifo_room_flag, image_transfer_busy);
endinterface : shade_if
`default_nettype wire

// File: rtl/shade_pkg.sv
// Constants and types shared by the shading engine pin model and its host end.
// Assumes one 100 MHz clock and an active-low asynchronous reset on both ends.
package shade_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int MA_W = 26;
    localparam int COORD_W = 13;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 4'h8;
    localparam logic [CNT_W-1:0] PIXEL_COUNT = 4'h4;
    localparam int PEND_LEAD = 2;
    localparam int DEPTH_LAG = 2;
    localparam logic [CNT_W-1:0] LAST_PIXEL = 4'h1;
    localparam logic [2:0] HOST_WR_LAST = 3'h3;
    localparam logic [2:0] HOST_RD_LAST = 3'h4;
    localparam logic [DATA_W-1:0] MASK_ALL = 16'hffff;
    // Command address codes seen on the four address lines.
    localparam logic [ADDR_W-1:0] CMD_DRAW = 4'h0;
    localparam logic [ADDR_W-1:0] CMD_DRAW16 = 4'h1;
    localparam logic [ADDR_W-1:0] CMD_LINEAR = 4'h2;
    localparam logic [ADDR_W-1:0] CMD_IMAGE_IN = 4'h3;
    localparam logic [ADDR_W-1:0] CMD_DEPTH_RD = 4'h4;
    localparam logic [ADDR_W-1:0] CMD_AG_SRC = 4'h5;
    localparam logic [ADDR_W-1:0] CMD_AG_DST = 4'h6;
    localparam logic [ADDR_W-1:0] CMD_PASS = 4'hf;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SYNC, ST_PEND, ST_ROW, ST_COL, ST_DONE
    } eng_state_t;
    typedef enum logic [1:0] {H_IDLE, H_WR, H_RD, H_GAP} host_state_t;
endpackage : shade_pkg

// File: rtl/strobe_sync.sv
// Two-stage synchroniser with a falling-edge pulse for an active-low strobe.
// Assumes the input idles high.
`timescale 1ns/1ps
`default_nettype none
module strobe_sync
    import shade_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic strobe_n,
    output logic level_n,
    output logic fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= strobe_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign level_n = s2_q;
    assign fall = s3_q & ~s2_q;
endmodule : strobe_sync
`default_nettype wire

// File: tb/shade_engine_pin_interface_tb.sv
// Bench joining the engine and its host end through the pin bundle.
// Assumes one 100 MHz clock; the bench plays the video memories.
`timescale 1ns/1ps
`default_nettype none
module shade_engine_pin_interface_tb;
    import shade_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic [ADDR_W-1:0] req_addr = 4'h0;
    logic [DATA_W-1:0] req_data = 16'h0;
    logic [DATA_W-1:0] mem_val = 16'h0;
    logic [DATA_W-1:0] old_depth = 16'h0;
    logic wait_req = 1'b0;
    logic sync_ready_in = 1'b1;
    logic [DATA_W-1:0] rsp_data, intensity_out, int_wire, depth_seen, pass_d;
    logic req_ready, rsp_valid, intensity_oe, pend_n, row_n, float_ack, drive_en;
    logic bps, spf, ioe_n, zoe_n, row_q, pend_q, col_n, col_q;
    int fail_count = 0;
    int checks_done = 0;
    int row_falls = 0;
    int pend_falls = 0;
    int col_falls = 0;
    logic [DATA_W-1:0] exp_q[$];
    logic [ADDR_W-1:0] codes[9] = '{CMD_DRAW, CMD_DRAW16, CMD_LINEAR, CMD_IMAGE_IN,
        CMD_DEPTH_RD, CMD_AG_SRC, CMD_AG_DST, CMD_DRAW, CMD_DRAW16};
    // The intensity bus carries the engine's value while it drives, memory data otherwise.
    assign int_wire = intensity_oe ? intensity_out : mem_val;
    always #5 core_clk = ~core_clk;
    shade_if hbus ();
    shade_engine shade_engine_i (.core_clk(core_clk), .resetn(resetn), .hbus(hbus.device),
        .vram_address_bus(), .vram_drive_en(drive_en), .row_strobe_n(row_n),
        .col_strobe_n(col_n), .ibuf_transfer_oe_n(ioe_n), .zbuf_transfer_oe_n(zoe_n),
        .ibuf_write_enable_n(), .zbuf_write_enable_n(), .zsect_write_enable_n(),
        .mem_read_not_write(), .intensity_out(intensity_out), .intensity_oe(intensity_oe),
        .intensity_in(int_wire), .new_depth_bus(), .old_depth_bus(old_depth),
        .depth_result(depth_seen), .wait_req(wait_req), .float_ack(float_ack),
        .block_pixel_select(bps), .sixteen_pixel_flag(spf), .mask_index_select(),
        .sync_ready_out(), .sync_ready_in(sync_ready_in), .vram_access_pending_n(pend_n),
        .first_pixel_flag_n(), .scan_left_flag(), .scan_right_flag(), .scan_up_flag(),
        .scan_down_flag());
    shade_host shade_host_i (.core_clk(core_clk), .resetn(resetn), .hbus(hbus.host),
        .req_valid(req_valid), .req_read(req_read), .req_addr(req_addr),
        .req_data(req_data), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid));
    shade_pins_assertions shade_pins_assertions_i (.core_clk(core_clk), .resetn(resetn),
        .d_host_oe(hbus.d_host_oe), .d_dev_oe(hbus.d_dev_oe),
        .host_read_strobe_n(hbus.host_read_strobe_n),
        .channel_busy_flag(hbus.channel_busy_flag), .fifo_room_flag(hbus.fifo_room_flag),
        .vram_access_pending_n(pend_n), .row_strobe_n(row_n), .wait_req(wait_req),
        .float_ack(float_ack), .vram_drive_en(drive_en), .block_pixel_select(bps),
        .sixteen_pixel_flag(spf), .ibuf_transfer_oe_n(ioe_n), .zbuf_transfer_oe_n(zoe_n));
    always @(posedge core_clk) begin
        row_q <= row_n;
        pend_q <= pend_n;
        col_q <= col_n;
        if (col_q === 1'b1 && col_n === 1'b0) col_falls++;
        if (row_q === 1'b1 && row_n === 1'b0) row_falls++;
        if (pend_q === 1'b1 && pend_n === 1'b0) pend_falls++;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic timeout(input string what);
        fail_count++;
        $display("BAD t=%0t timeout %s", $time, what);
        final_report();
    endtask : timeout
    task automatic host_op(input logic rd, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_read = rd;
        req_addr = a;
        req_data = d;
        do begin
            @(posedge core_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        if (n >= 200) timeout("request");
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask : host_op
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (20) @(negedge core_clk);
        while (hbus.channel_busy_flag !== 1'b0 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 3000) timeout("idle");
    endtask : wait_idle
    initial begin
        int n, base, cbase;
        void'($urandom(32'hc385));
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        check(hbus.fifo_room_flag, 1, "room after reset");
        check(hbus.channel_busy_flag, 0, "busy after reset");
        $display("test reset done");
        // Sync held off: the first command parks, the other eight fill the FIFO.
        for (int i = 0; i < 9; i++) begin
            host_op(1'b0, codes[i], 16'($urandom));
            repeat (4) @(negedge core_clk);
            check(hbus.fifo_room_flag, i < FIFO_DEPTH, "room flag");
            check(hbus.channel_busy_flag, 1, "busy while queued");
        end
        $display("test fill done");
        sync_ready_in = 1'b0;
        old_depth = 16'($urandom);
        repeat (20) @(negedge core_clk);
        wait_req = 1'b1;
        repeat (3) @(negedge core_clk);
        check(float_ack, 1, "float ack");
        check(drive_en, 0, "pins floated");
        wait_req = 1'b0;
        repeat (2) @(negedge core_clk);
        check(float_ack, 0, "ack released");
        wait_idle();
        // The row strobe stays low for a whole command; each pixel gets a column strobe.
        check(row_falls, 9, "page accesses");
        check(col_falls, 9 * PIXEL_COUNT, "pixel accesses");
        check(pend_falls, 9, "access announcements");
        check(hbus.fifo_room_flag, 1, "room after drain");
        $display("test drain done");
        base = row_falls;
        cbase = col_falls;
        pass_d = 16'($urandom);
        host_op(1'b0, CMD_PASS, pass_d);
        repeat (4) @(negedge core_clk);
        check(hbus.image_transfer_busy, 1, "image busy in pass");
        wait_idle();
        check(hbus.image_transfer_busy, 0, "image busy after pass");
        check(row_falls - base, 1, "pass-through access");
        check(col_falls - cbase, 1, "pass-through column");
        check(depth_seen, (old_depth < pass_d) ? old_depth : pass_d, "depth compare");
        $display("test pass done");
        for (int k = 0; k < 4; k++) begin
            mem_val = 16'($urandom);
            exp_q.push_back(mem_val);
            host_op(1'b1, 4'h0, 16'h0);
            n = 0;
            while (rsp_valid !== 1'b1 && n < 100) begin
                @(negedge core_clk);
                n++;
            end
            if (n >= 100) timeout("read");
            check(rsp_data, exp_q.pop_front(), "read data");
        end
        $display("test read done");
        sync_ready_in = 1'b1;
        host_op(1'b0, CMD_DRAW, 16'h8001);
        repeat (4) @(negedge core_clk);
        check(hbus.channel_busy_flag, 1, "busy before reset");
        resetn = 1'b0;
        @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        check(hbus.channel_busy_flag, 0, "busy after short reset");
        check(hbus.fifo_room_flag, 1, "room after short reset");
        $display("test short reset done");
        final_report();
    end
endmodule : shade_engine_pin_interface_tb
`default_nettype wire

// File: tb/shade_pins_assertions.sv
// Checker for the host bundle and the engine's memory-side pins.
// Assumes the bench top instantiates it beside the interface and wires the engine pins.
`timescale 1ns/1ps
`default_nettype none
module shade_pins_assertions (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic d_host_oe,
    input wire logic d_dev_oe,
    input wire logic host_read_strobe_n,
    input wire logic channel_busy_flag,
    input wire logic fifo_room_flag,
    input wire logic vram_access_pending_n,
    input wire logic row_strobe_n,
    input wire logic wait_req,
    input wire logic float_ack,
    input wire logic vram_drive_en,
    input wire logic block_pixel_select,
    input wire logic sixteen_pixel_flag,
    input wire logic ibuf_transfer_oe_n,
    input wire logic zbuf_transfer_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_row_quiet;
        row_strobe_n ##1 row_strobe_n;
    endsequence
    property p_bus_dir; !(d_host_oe && d_dev_oe); endproperty
    property p_read_sync; $fell(host_read_strobe_n) |-> !d_dev_oe; endproperty
    property p_read_drive; $rose(d_dev_oe) |-> !host_read_strobe_n; endproperty
    property p_full_busy; !fifo_room_flag |-> channel_busy_flag; endproperty
    property p_pend_busy; !vram_access_pending_n |-> channel_busy_flag; endproperty
    property p_pend_lead;
        disable iff (!resetn || wait_req)
        $fell(vram_access_pending_n) |-> s_row_quiet ##[0:3] !row_strobe_n;
    endproperty
    property p_float_ack; $rose(wait_req) |=> float_ack; endproperty
    property p_float_now; wait_req |-> !vram_drive_en; endproperty
    property p_resume; $fell(wait_req) |=> !float_ack; endproperty
    property p_mode_pair; block_pixel_select == sixteen_pixel_flag; endproperty
    property p_one_xfer; !(!ibuf_transfer_oe_n && !zbuf_transfer_oe_n); endproperty
    property p_reset_idle;
        disable iff (1'b0) !resetn |=> fifo_room_flag && !channel_busy_flag;
    endproperty
    a_bus_dir: assert property (p_bus_dir) else $error("both ends drive data");
    a_read_sync: assert property (p_read_sync) else $error("read not synchronised");
    a_read_drive: assert property (p_read_drive) else $error("drive without read");
    a_full_busy: assert property (p_full_busy) else $error("full but not busy");
    a_pend_busy: assert property (p_pend_busy) else $error("access but not busy");
    a_pend_lead: assert property (p_pend_lead) else $error("pending lead wrong");
    a_float_ack: assert property (p_float_ack) else $error("no float ack");
    a_float_now: assert property (p_float_now) else $error("pins not floated");
    a_resume: assert property (p_resume) else $error("ack stuck after wait");
    a_mode_pair: assert property (p_mode_pair) else $error("mode pins disagree");
    a_one_xfer: assert property (p_one_xfer) else $error("both transfers on");
    a_reset_idle: assert property (p_reset_idle) else $error("not idle in reset");
endmodule : shade_pins_assertions
`default_nettype wire
